// File: shared/occd_pkg.sv
package occd_pkg;

	localparam int unsigned NUM_CH = 8;

	// ----------------------------------------------------------------
	// Register offsets.
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_SIDE = 4'h0;
	localparam logic [3:0] ADDR_TYPE = 4'h1;
	localparam logic [3:0] ADDR_ARRANGE = 4'h2;
	localparam logic [3:0] ADDR_EFF_SIDE = 4'h3;
	localparam logic [3:0] ADDR_EFF_TYPE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_DRIVE = 4'h6;

	// ----------------------------------------------------------------
	// Field positions in the arrangement register.
	// ----------------------------------------------------------------
	localparam int unsigned ARR_PH_A_BIT = 0;
	localparam int unsigned ARR_PH_B_BIT = 1;
	localparam int unsigned ARR_BR_A_BIT = 2;
	localparam int unsigned ARR_BR_B_BIT = 3;

	// ----------------------------------------------------------------
	// Field positions in the status register.
	// ----------------------------------------------------------------
	localparam int unsigned STAT_INVALID_BIT = 0;
	localparam int unsigned STAT_PTYPE_LS_BIT = 1;
	localparam int unsigned STAT_EN6_BIT = 2;
	localparam int unsigned STAT_DIS_BIT = 3;

	// ----------------------------------------------------------------
	// Reset values: all low side, N type, no arrangement.
	// ----------------------------------------------------------------
	localparam logic [7:0] SIDE_RST = 8'h00;
	localparam logic [7:0] TYPE_RST = 8'h00;
	localparam logic [3:0] ARRANGE_RST = 4'h0;

	// Channels not switched off by the external disable inputs.
	localparam logic [7:0] DIS_IMMUNE_MASK = 8'hc0;
	// Channel gated by the dedicated channel-six enable.
	localparam logic [7:0] EN6_MASK = 8'h20;

	// Bridge decode state.
	typedef enum logic [2:0] {
		OCCD_MODE_PLAIN = 3'h1,
		OCCD_MODE_PH = 3'h2,
		OCCD_MODE_BRIDGE = 3'h4
	} occd_mode_e;

endpackage

// File: shared/occd_cfg_if.sv
interface occd_cfg_if;
	logic [7:0] side_sel;
	logic [7:0] type_sel;
	logic [3:0] arrange;
	logic [7:0] eff_side;
	logic [7:0] eff_type;
	logic invalid;
	logic ptype_ls;

	modport ctrl (output side_sel, output type_sel, output arrange,
		input eff_side, input eff_type, input invalid, input ptype_ls);
	modport dec (input side_sel, input type_sel, input arrange,
		output eff_side, output eff_type, output invalid, output ptype_ls);
endinterface

// File: core/occd_role_decode.sv
module occd_role_decode (
	occd_cfg_if.dec cfg
);

	wire ph_a = cfg.arrange[occd_pkg::ARR_PH_A_BIT];
	wire ph_b = cfg.arrange[occd_pkg::ARR_PH_B_BIT];
	wire br_a = cfg.arrange[occd_pkg::ARR_BR_A_BIT];
	wire br_b = cfg.arrange[occd_pkg::ARR_BR_B_BIT];

	// Both pair selections share channels 1..4 with bridge A; when both are set the
	// bridge wins, since its roles contain the pair roles in full.
	wire ph_a_eff = ph_a & ~br_a;
	wire ph_b_eff = ph_b & ~br_a;

	// Claim masks and forced roles (1 = high side), channel 1 in bit 0.
	wire [7:0] claim_mask = {8{ph_a_eff}} & 8'h09
		| {8{ph_b_eff}} & 8'h06
		| {8{br_a}} & 8'h0f
		| {8{br_b}} & 8'hf0;
	wire [7:0] forced_side = {8{ph_a_eff}} & 8'h01
		| {8{ph_b_eff}} & 8'h02
		| {8{br_a}} & 8'h03
		| {8{br_b}} & 8'h30;

	// Claimed channels take the forced role; the rest keep their own side bit.
	assign cfg.eff_side = (claim_mask & forced_side) | (~claim_mask & cfg.side_sel);
	// P type is kept only where the effective side is high.
	assign cfg.eff_type = cfg.type_sel & cfg.eff_side;
	assign cfg.ptype_ls = |(cfg.type_sel & ~cfg.eff_side);
	assign cfg.invalid = br_a & (ph_a | ph_b);

endmodule

// File: core/occd_top.sv
module occd_top #(
	parameter int unsigned NUM_CH = occd_pkg::NUM_CH
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] channel_on_n_i,
	input wire logic channel_six_enable_in_i,
	input wire logic external_disable_hi_i,
	input wire logic external_disable_lo_i,
	output logic [7:0] drive_on_o,
	output logic [7:0] drive_high_side_o,
	output logic [7:0] drive_p_type_o,
	output logic config_invalid_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	logic [10:0] pin_meta_q;
	logic [10:0] pin_sync_q;
	wire [10:0] pin_raw = {external_disable_lo_i, external_disable_hi_i,
		channel_six_enable_in_i, channel_on_n_i};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// Inputs idle as released: channels off, disable low-active inactive.
			pin_meta_q <= 11'h4ff;
			pin_sync_q <= 11'h4ff;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	wire [7:0] on_n_s = pin_sync_q[7:0];
	wire en6_s = pin_sync_q[8];
	wire dis_hi_s = pin_sync_q[9];
	wire dis_lo_s = pin_sync_q[10];
	// Either disable source is enough; the two are redundant by design.
	wire disable_s = dis_hi_s | ~dis_lo_s;

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	logic [7:0] side_q;
	logic [7:0] type_q;
	logic [3:0] arrange_q;

	wire wr_side = wr_i & (addr_i == occd_pkg::ADDR_SIDE);
	wire wr_type = wr_i & (addr_i == occd_pkg::ADDR_TYPE);
	wire wr_arr = wr_i & (addr_i == occd_pkg::ADDR_ARRANGE);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			side_q <= occd_pkg::SIDE_RST;
			type_q <= occd_pkg::TYPE_RST;
			arrange_q <= occd_pkg::ARRANGE_RST;
		end else begin
			if (wr_side) begin
				side_q <= wdata_i;
			end
			if (wr_type) begin
				type_q <= wdata_i;
			end
			if (wr_arr) begin
				arrange_q <= wdata_i[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Role decoding.
	// ----------------------------------------------------------------
	occd_cfg_if cfg ();

	assign cfg.side_sel = side_q;
	assign cfg.type_sel = type_q;
	assign cfg.arrange = arrange_q;

	occd_role_decode u_decode (
		.cfg(cfg)
	);

	// ----------------------------------------------------------------
	// Drive command.
	// ----------------------------------------------------------------
	wire br_a = arrange_q[occd_pkg::ARR_BR_A_BIT];
	wire br_b = arrange_q[occd_pkg::ARR_BR_B_BIT];

	// Bridge inputs: PWM low-active, direction, high impedance.
	function automatic logic [3:0] bridge_drive(input logic pwm_n, input logic dir,
		input logic bridge_high_impedance);
		logic on;
		on = ~pwm_n & ~bridge_high_impedance;
		// Order: high 1, high 2, low 1, low 2; direction picks the diagonal.
		bridge_drive = {on & ~dir, on & dir, on & dir, on & ~dir};
	endfunction

	wire [3:0] br_a_drv = bridge_drive(on_n_s[0], on_n_s[1], on_n_s[2]);
	wire [3:0] br_b_drv = bridge_drive(on_n_s[4], on_n_s[5], on_n_s[6]);

	// Channels bridge roles: 1,2 high, 3,4 low. Map {lo2,lo1,hi2,hi1}.
	wire [7:0] plain_on = ~on_n_s;
	wire [7:0] cmd_on;
	assign cmd_on[3:0] = br_a ? br_a_drv : plain_on[3:0];
	assign cmd_on[7:4] = br_b ? br_b_drv : plain_on[7:4];

	wire [7:0] gate_dis = disable_s ? occd_pkg::DIS_IMMUNE_MASK : 8'hff;
	wire [7:0] gate_en6 = en6_s ? 8'hff : ~occd_pkg::EN6_MASK;
	wire [7:0] drive_d = cmd_on & gate_dis & gate_en6;

	logic [7:0] drive_q;
	logic [7:0] high_q;
	logic [7:0] ptype_q;
	logic invalid_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_q <= 8'h00;
			high_q <= 8'h00;
			ptype_q <= 8'h00;
			invalid_q <= 1'b0;
		end else begin
			drive_q <= drive_d;
			high_q <= cfg.eff_side;
			ptype_q <= cfg.eff_type;
			invalid_q <= cfg.invalid;
		end
	end

	assign drive_on_o = drive_q;
	assign drive_high_side_o = high_q;
	assign drive_p_type_o = ptype_q;
	assign config_invalid_o = invalid_q;

	// ----------------------------------------------------------------
	// Read port.
	// ----------------------------------------------------------------
	wire [7:0] status = {4'h0, disable_s, en6_s, cfg.ptype_ls, cfg.invalid};

	logic [7:0] rdata_d;
	always_comb begin
		case (addr_i)
			occd_pkg::ADDR_SIDE: rdata_d = side_q;
			occd_pkg::ADDR_TYPE: rdata_d = type_q;
			occd_pkg::ADDR_ARRANGE: rdata_d = {4'h0, arrange_q};
			occd_pkg::ADDR_EFF_SIDE: rdata_d = cfg.eff_side;
			occd_pkg::ADDR_EFF_TYPE: rdata_d = cfg.eff_type;
			occd_pkg::ADDR_STATUS: rdata_d = status;
			occd_pkg::ADDR_DRIVE: rdata_d = drive_q;
			default: rdata_d = 8'h00;
		endcase
	end

	logic [7:0] rdata_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 8'h00;
		end else begin
			// Data stands only in the cycle after the read strobe.
			rdata_q <= rd_i ? rdata_d : 8'h00;
		end
	end

	assign rdata_o = rdata_q;

endmodule

// File: bench/occd_asserts.sv
module occd_asserts #(
	parameter int unsigned NUM_CH = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] channel_on_n_i,
	input wire logic channel_six_enable_in_i,
	input wire logic external_disable_hi_i,
	input wire logic external_disable_lo_i,
	input wire logic [7:0] drive_on_o,
	input wire logic [7:0] drive_high_side_o,
	input wire logic [7:0] drive_p_type_o,
	input wire logic config_invalid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Pin checks wait four cycles so the two-flop synchroniser has settled.
	wire logic arr_wr = wr_i && addr_i == occd_pkg::ADDR_ARRANGE;
	wire logic clash = wdata_i[2] && (wdata_i[0] || wdata_i[1]);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	p_low_side_a: assert property ((drive_p_type_o & ~drive_high_side_o) == 8'h00)
		else $error("P type on a low-side channel");
	six_gate_a: assert property (!channel_six_enable_in_i [*4] |-> !drive_on_o[5])
		else $error("Channel six on without enable");
	dis_hi_off_a: assert property (external_disable_hi_i [*4] |-> (drive_on_o & 8'h3f) == 8'h00)
		else $error("Channel on while high disable held");
	dis_lo_off_a: assert property (!external_disable_lo_i [*4] |-> (drive_on_o & 8'h3f) == 8'h00)
		else $error("Channel on while low disable held");
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("Read data outside read cycle");
	// The register loads on the write edge and the output flop on the next one,
	// so the new roles are first seen two sampled edges after the write.
	bridge_a_sides_a: assert property (arr_wr && wdata_i[2] |-> ##2 drive_high_side_o[3:0] == 4'h3)
		else $error("Bridge A sides wrong");
	bridge_b_sides_a: assert property (arr_wr && wdata_i[3] |-> ##2 drive_high_side_o[7:4] == 4'h3)
		else $error("Bridge B sides wrong");
	pair_a_sides_a: assert property (arr_wr && wdata_i[0] && !wdata_i[2]
		|-> ##2 drive_high_side_o[0] && !drive_high_side_o[3]) else $error("Pair A sides wrong");
	invalid_flag_a: assert property (arr_wr |-> ##2 config_invalid_o == $past(clash, 2))
		else $error("Invalid flag wrong");
endmodule

bind occd_top occd_asserts #(.NUM_CH(NUM_CH)) u_asserts (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .channel_on_n_i(channel_on_n_i),
	.channel_six_enable_in_i(channel_six_enable_in_i),
	.external_disable_hi_i(external_disable_hi_i), .external_disable_lo_i(external_disable_lo_i),
	.drive_on_o(drive_on_o), .drive_high_side_o(drive_high_side_o),
	.drive_p_type_o(drive_p_type_o), .config_invalid_o(config_invalid_o)
);

// File: bench/occd_host_pins.sv
module occd_host_pins (
	input wire logic clk_i,
	output logic [7:0] channel_on_n_o,
	output logic six_enable_o,
	output logic disable_hi_o,
	output logic disable_lo_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels mirror the pulled-up pins: every channel off, nothing disabled.
	initial begin
		channel_on_n_o = 8'hff;
		six_enable_o = 1'b0;
		disable_hi_o = 1'b0;
		disable_lo_n_o = 1'b1;
	end
	// In a bridge the low three bits of its pin nibble are PWM, direction and high impedance.
	task drive(input logic [7:0] on_n, input logic en6, input logic hi, input logic lo_n);
		@(posedge clk_i);
		channel_on_n_o <= on_n;
		six_enable_o <= en6;
		disable_hi_o <= hi;
		disable_lo_n_o <= lo_n;
	endtask
endmodule

// File: bench/tb_output_channel_config_decoder.sv
module tb_output_channel_config_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] on_n, rdata, drv, hs, pt;
	logic en6, dhi, dlo_n, inval;
	int fail_count = 0;
	int checked = 0;
	always #20 clk_i = ~clk_i;
	occd_host_pins host (.clk_i(clk_i), .channel_on_n_o(on_n), .six_enable_o(en6),
		.disable_hi_o(dhi), .disable_lo_n_o(dlo_n));
	occd_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .channel_on_n_i(on_n),
		.channel_six_enable_in_i(en6), .external_disable_hi_i(dhi),
		.external_disable_lo_i(dlo_n), .drive_on_o(drv), .drive_high_side_o(hs),
		.drive_p_type_o(pt), .config_invalid_o(inval));
	task stop_test();
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata;
	endtask
	task t_regs();
		logic [7:0] v;
		wr_reg(4'h3, 8'hff);
		for (int a = 0; a < 4; a++) begin
			rd_reg(4'(a), v);
			check(v, 8'h00);
		end
		rd_reg(4'hf, v);
		check(v, 8'h00);
	endtask
	task t_side_type();
		logic [7:0] v;
		wr_reg(4'h0, 8'h0f);
		wr_reg(4'h1, 8'h3c);
		tick(1);
		check(hs, 8'h0f);
		check(pt, 8'h0c);
		rd_reg(4'h5, v);
		check(v, 8'h06);
	endtask
	task t_arrange();
		logic [7:0] e;
		wr_reg(4'h0, 8'h5a);
		wr_reg(4'h1, 8'hff);
		for (int a = 0; a < 16; a++) begin
			wr_reg(4'h2, 8'(a));
			tick(1);
			e = 8'h5a;
			if (a[0]) e = (e & 8'hf6) | 8'h01;
			if (a[1]) e = (e & 8'hf9) | 8'h02;
			if (a[2]) e = (e & 8'hf0) | 8'h03;
			if (a[3]) e = (e & 8'h0f) | 8'h30;
			check(hs, e);
			check(pt, e);
			check({7'h00, inval}, {7'h00, a[2] & (a[0] | a[1])});
		end
	endtask
	task automatic t_pins();
		logic [7:0] ar[10] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h4, 8'h4, 8'h4, 8'h8, 8'h8, 8'h8};
		logic [7:0] pn[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hf8, 8'hfa, 8'hfc,
			8'h8f, 8'haf, 8'haf};
		logic [2:0] ctl[10] = '{3'h5, 3'h1, 3'h7, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h1};
		logic [7:0] ex[10] = '{8'hff, 8'hdf, 8'hc0, 8'hc0, 8'h09, 8'h06, 8'h00,
			8'h90, 8'h60, 8'h40};
		logic [7:0] v;
		for (int i = 0; i < 10; i++) begin
			wr_reg(4'h2, ar[i]);
			host.drive(pn[i], ctl[i][2], ctl[i][1], ctl[i][0]);
			tick(3);
			check(drv, ex[i]);
			if (i == 2) begin
				rd_reg(4'h5, v);
				check(v, 8'h0e);
			end
		end
		rd_reg(4'h6, v);
		check(v, 8'h40);
		rd_reg(4'h5, v);
		check(v, 8'h02);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		host.drive(8'hff, 1'b1, 1'b0, 1'b1);
		tick(3);
		t_regs();
		t_side_type();
		t_arrange();
		t_pins();
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		stop_test();
	end
endmodule
